// [src/flag_unit_pkg.sv]
// Shared constants, types and decoders for the flag unit
package flag_unit_pkg;
  // Data and address widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 24;
  localparam int WB_AW = 4;
  // Register byte offsets
  localparam logic [3:0] FLAGS_OFF = 4'h0;
  localparam logic [3:0] RESULT_OFF = 4'h4;
  // Flag positions in the condition register
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_U = 4;
  localparam int FLAG_H = 5;
  localparam int NFLAGS = 6;
  localparam int CREG_W = 8;
  localparam logic [5:0] FLAGS_RST = 6'h00;
  // Operand geometry
  localparam int BIT_IDX_W = 3;
  localparam int MSB_BYTE = 7;
  localparam int MSB_WORD = 15;
  localparam int MSB_LONG = 31;
  localparam int HC_BYTE = 3;
  localparam int HC_WORD = 11;
  localparam int HC_LONG = 27;
  localparam logic [31:0] MASK_BYTE = 32'h0000_00FF;
  localparam logic [31:0] MASK_WORD = 32'h0000_FFFF;
  localparam logic [31:0] MASK_LONG = 32'hFFFF_FFFF;
  // Decimal adjust constants
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
  localparam logic [7:0] ADJ_LO = 8'h06;
  localparam logic [7:0] ADJ_HI = 8'h60;
  // Flag update masks, one bit per flag position
  localparam logic [5:0] UPD_ARITH = 6'h2F;
  localparam logic [5:0] UPD_MOVE = 6'h0E;
  localparam logic [5:0] UPD_SHIFT = 6'h0F;
  localparam logic [5:0] UPD_CARRY = 6'h01;
  localparam logic [5:0] UPD_DAA = 6'h0D;
  localparam logic [5:0] UPD_DAS = 6'h0C;
  localparam logic [5:0] UPD_ALL = 6'h3F;
  localparam logic [5:0] UPD_NONE = 6'h00;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2
  } size_type;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ADD = 5'h01, OP_ADDC = 5'h02, OP_SUB = 5'h03,
    OP_SUBC = 5'h04, OP_MOV = 5'h05, OP_SHL = 5'h06, OP_SHR = 5'h07,
    OP_ROTL = 5'h08, OP_ROTR = 5'h09, OP_BLD = 5'h0A, OP_BST = 5'h0B,
    OP_BAND = 5'h0C, OP_BOR = 5'h0D, OP_BXOR = 5'h0E,
    DECIMAL_ADJUST_ADD = 5'h0F, DECIMAL_ADJUST_SUB = 5'h10,
    LOAD_FLAGS_INSTR = 5'h11, STORE_FLAGS_INSTR = 5'h12,
    AND_FLAGS_INSTR = 5'h13, OR_FLAGS_INSTR = 5'h14, XOR_FLAGS_INSTR = 5'h15
  } op_type;

  typedef enum logic [3:0] {
    COND_ALWAYS = 4'h0, COND_NEVER = 4'h1, COND_HI = 4'h2, COND_LS = 4'h3,
    COND_CC = 4'h4, COND_CS = 4'h5, COND_NE = 4'h6, COND_EQ = 4'h7,
    COND_VC = 4'h8, COND_VS = 4'h9, COND_PL = 4'hA, COND_MI = 4'hB,
    COND_GE = 4'hC, COND_LT = 4'hD, COND_GT = 4'hE, COND_LE = 4'hF
  } cond_type;

  // Value mask of an operand size
  function automatic logic [31:0] size_mask(size_type s);
    return (s == SZ_BYTE) ? MASK_BYTE : (s == SZ_WORD) ? MASK_WORD : MASK_LONG;
  endfunction

  // Sign bit position of an operand size
  function automatic int msb_pos(size_type s);
    return (s == SZ_BYTE) ? MSB_BYTE : (s == SZ_WORD) ? MSB_WORD : MSB_LONG;
  endfunction

  // Bit that receives the half carry of an operand size
  function automatic int half_pos(size_type s);
    return ((s == SZ_BYTE) ? HC_BYTE : (s == SZ_WORD) ? HC_WORD : HC_LONG) + 1;
  endfunction

  // Operations that always work on one byte
  function automatic logic is_byte_op(op_type op);
    return op inside {OP_BLD, OP_BST, OP_BAND, OP_BOR, OP_BXOR,
                      DECIMAL_ADJUST_ADD, DECIMAL_ADJUST_SUB};
  endfunction

  // Flags written by each operation
  function automatic logic [5:0] flag_mask(op_type op);
    unique case (op)
      OP_ADD, OP_ADDC, OP_SUB, OP_SUBC: return UPD_ARITH;
      OP_MOV: return UPD_MOVE;
      OP_SHL, OP_SHR, OP_ROTL, OP_ROTR: return UPD_SHIFT;
      OP_BLD, OP_BAND, OP_BOR, OP_BXOR: return UPD_CARRY;
      DECIMAL_ADJUST_ADD: return UPD_DAA;
      DECIMAL_ADJUST_SUB: return UPD_DAS;
      LOAD_FLAGS_INSTR, AND_FLAGS_INSTR: return UPD_ALL;
      OR_FLAGS_INSTR, XOR_FLAGS_INSTR: return UPD_ALL;
      default: return UPD_NONE;
    endcase
  endfunction
endpackage

// [src/alu_if.sv]
// Operand and result bundle between the flag unit and its datapath
`timescale 1ns/1ps
interface alu_if
  import flag_unit_pkg::*;
();
  op_type op;                 // Operation
  size_type size;             // Operand size
  logic [DATA_W-1:0] opa;     // Destination operand
  logic [DATA_W-1:0] opb;     // Source operand
  logic [BIT_IDX_W-1:0] bit_idx; // Selected bit of a byte
  logic cin;                  // Current carry flag
  logic hin;                  // Current half-carry flag
  logic [DATA_W-1:0] result;  // Masked result
  logic n;                    // Candidate sign flag
  logic z;                    // Candidate zero flag
  logic v;                    // Candidate overflow flag
  logic c;                    // Candidate carry flag
  logic h;                    // Candidate half-carry flag

  modport core (input op, size, opa, opb, bit_idx, cin, hin,
                output result, n, z, v, c, h);
  modport user (output op, size, opa, opb, bit_idx, cin, hin,
                input result, n, z, v, c, h);
endinterface

// [src/flag_alu.sv]
// Combinational datapath producing results and candidate flags
`timescale 1ns/1ps
module flag_alu
  import flag_unit_pkg::*;
(
  // Datapath bundle
  alu_if.core io
);
  size_type sz;              // Effective size
  logic [DATA_W-1:0] m;      // Size mask
  logic [DATA_W-1:0] a;      // Masked first operand
  logic [DATA_W-1:0] b;      // Masked second operand
  logic [DATA_W-1:0] r;      // Working result
  logic [DATA_W:0] sum;      // Sum with carry-out room
  logic [7:0] corr;          // Decimal correction
  logic cin_use;             // Carry folded into sum
  logic bitv;                // Selected operand bit
  logic sa;                  // First operand sign
  logic sb;                  // Second operand sign
  int msb;                   // Sign bit index
  int hb;                    // Half carry bit index

  // Result and flag candidates for the current operation
  always_comb begin
    sz = is_byte_op(io.op) ? SZ_BYTE : io.size; // RULE9
    m = size_mask(sz);
    msb = msb_pos(sz);
    hb = half_pos(sz);
    a = io.opa & m;
    b = io.opb & m;
    sa = a[msb];
    sb = b[msb];
    cin_use = (io.op == OP_ADDC || io.op == OP_SUBC) && io.cin;
    bitv = io.opa[io.bit_idx]; // RULE10
    sum = '0;
    corr = '0;
    r = a;
    io.c = io.cin;
    io.v = 1'h0;
    io.h = io.hin;
    unique case (io.op)
      // Addition, carry out of the sign bit
      OP_ADD, OP_ADDC: begin
        sum = {1'h0, a} + {1'h0, b} + {{DATA_W{1'h0}}, cin_use};
        r = sum[DATA_W-1:0];
        io.c = sum[msb+1]; // RULE5
        io.v = (sa == sb) && (sum[msb] != sa); // RULE4
        io.h = a[hb] ^ b[hb] ^ sum[hb]; // RULE15
      end
      // Subtraction, carry means borrow
      OP_SUB, OP_SUBC: begin
        sum = {1'h0, a} - {1'h0, b} - {{DATA_W{1'h0}}, cin_use};
        r = sum[DATA_W-1:0];
        io.c = sum[msb+1]; // RULE6
        io.v = (sa != sb) && (sum[msb] != sa); // RULE4
        io.h = a[hb] ^ b[hb] ^ sum[hb]; // RULE15
      end
      // Shifts and rotates by one place
      OP_SHL: begin
        r = a << 1;
        io.c = a[msb]; // RULE7
      end
      OP_SHR: begin
        r = a >> 1;
        io.c = a[0]; // RULE7
      end
      OP_ROTL: begin
        r = a << 1;
        r[0] = a[msb];
        io.c = a[msb]; // RULE7
      end
      OP_ROTR: begin
        r = a >> 1;
        r[msb] = a[0];
        io.c = a[0]; // RULE7
      end
      // Carry as one-bit accumulator
      OP_BLD: io.c = bitv; // RULE8
      OP_BST: r[io.bit_idx] = io.cin; // RULE8
      OP_BAND: io.c = io.cin & bitv; // RULE8
      OP_BOR: io.c = io.cin | bitv; // RULE8
      OP_BXOR: io.c = io.cin ^ bitv; // RULE8
      // Byte as two packed decimal digits
      DECIMAL_ADJUST_ADD: begin
        io.c = io.cin | (a[7:0] > BCD_BYTE_MAX); // RULE11
        corr = ((io.hin || a[3:0] > BCD_DIGIT_MAX) ? ADJ_LO : 8'h00)
             | (io.c ? ADJ_HI : 8'h00);
        r[7:0] = a[7:0] + corr;
      end
      DECIMAL_ADJUST_SUB: begin
        corr = (io.hin ? ADJ_LO : 8'h00) | (io.cin ? ADJ_HI : 8'h00); // RULE11
        r[7:0] = a[7:0] - corr;
      end
      // Moves and anything else pass the operand
      default: r = a;
    endcase
    r = r & m;
  end

  // Sign and zero follow the masked result
  assign io.result = r;
  assign io.n = r[msb]; // RULE2
  assign io.z = (r == '0); // RULE3
endmodule

// [src/flag_unit.sv]
// Condition flag unit with operand datapath, branch test and alignment
//
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
// Function
// (RULE1) Bit 4 user bit, flag instructions only; a Wishbone write to the flag register also loads it when no instruction issues in its acknowledge cycle
// (RULE2) Sign flag copies result top bit
// (RULE3) Zero flag set on all-zero result
// (RULE4) Overflow flag set on signed overflow only
// (RULE5) Carry flag set on addition carry out
// (RULE6) Carry flag signals borrow on subtraction
// (RULE7) Carry takes bit shifted or rotated out
// (RULE8) Carry acts as bit-operation accumulator
// (RULE9) Operands: bit, decimal, byte, word, longword
// (RULE10) Bit index 0 to 7 within byte
// (RULE11) Decimal adjust treats byte as two digits
// (RULE12) Odd word data address forced even silently
// (RULE13) Odd fetch address forced even silently
// (RULE14) Software should use word stack accesses
// (RULE15) Half carry at bits 3, 11, 27
// (RULE16) Unaffected flags keep previous values
// (RULE17) Branch conditions use N, Z, V, C
// (RULE18) Flags update with result write-back cycle
module flag_unit
  import flag_unit_pkg::*;
(
  // Clock and reset
  input logic clk_i,
  input logic rst_i,
  // Wishbone slave
  input logic [WB_AW-1:0] wb_adr_i,
  input logic [DATA_W-1:0] wb_dat_i,
  output logic [DATA_W-1:0] wb_dat_o,
  input logic wb_we_i,
  input logic [3:0] wb_sel_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  output logic wb_ack_o,
  // Instruction issue
  input logic op_valid_i,
  input op_type op_i,
  input size_type size_i,
  input logic [DATA_W-1:0] opa_i,
  input logic [DATA_W-1:0] opb_i,
  input logic [BIT_IDX_W-1:0] bit_idx_i,
  input logic [7:0] imm_i,
  // Result write-back
  output logic [DATA_W-1:0] result_o,
  output logic result_valid_o,
  output logic [CREG_W-1:0] flags_o,
  // Branch test
  input cond_type cond_i,
  output logic branch_taken_o,
  // Address alignment
  input logic addr_req_i,
  input logic [ADDR_W-1:0] addr_i,
  input size_type addr_size_i,
  input logic addr_fetch_i,
  output logic [ADDR_W-1:0] addr_o,
  output logic addr_valid_o
);

  // Condition register state
  logic [NFLAGS-1:0] flags_q;
  logic [NFLAGS-1:0] flags_d;
  // Candidate flag values
  logic [NFLAGS-1:0] cand;
  // Flags the current operation writes
  logic [NFLAGS-1:0] mask_w;
  // Write-back registers
  logic [DATA_W-1:0] result_q;
  logic result_valid_q;
  // Alignment registers
  logic [ADDR_W-1:0] addr_q;
  logic addr_valid_q;
  // Bus slave state
  logic ack_q;
  logic [DATA_W-1:0] rdata_q;
  logic bus_req;
  logic bus_flag_wr;
  logic flag_load_any;

  // Datapath bundle
  alu_if alu ();

  // Datapath instance
  flag_alu alu_core (
    .io (alu.core)
  );

  // Drive datapath from the issue port and current flags
  assign alu.op = op_i;
  assign alu.size = size_i;
  assign alu.opa = opa_i;
  assign alu.opb = opb_i;
  assign alu.bit_idx = bit_idx_i;
  assign alu.cin = flags_q[FLAG_C];
  assign alu.hin = flags_q[FLAG_H];

  // Decoded update mask
  assign mask_w = flag_mask(op_i);

  // Bus request not yet answered
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;

  // Flag write lands on the acknowledge edge
  assign bus_flag_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q
                    && (wb_adr_i == FLAGS_OFF) && wb_sel_i[0];

  // Any path allowed to change the user bit
  assign flag_load_any = bus_flag_wr || (op_valid_i && mask_w[FLAG_U]);

  // Candidate flags from datapath or flag instruction
  always_comb begin
    cand = flags_q;
    cand[FLAG_H] = alu.h;
    cand[FLAG_N] = alu.n;
    cand[FLAG_Z] = alu.z;
    cand[FLAG_V] = alu.v;
    cand[FLAG_C] = alu.c;
    unique case (op_i)
      // Whole register loaded from immediate
      LOAD_FLAGS_INSTR: cand = imm_i[NFLAGS-1:0]; // RULE1
      // Logic on the register with immediate
      AND_FLAGS_INSTR: cand = flags_q & imm_i[NFLAGS-1:0]; // RULE1
      OR_FLAGS_INSTR: cand = flags_q | imm_i[NFLAGS-1:0]; // RULE1
      XOR_FLAGS_INSTR: cand = flags_q ^ imm_i[NFLAGS-1:0]; // RULE1
      // Datapath candidates
      default: cand[FLAG_U] = flags_q[FLAG_U];
    endcase
  end

  // Next flags: masked merge, else bus load, else hold
  always_comb begin
    flags_d = flags_q;
    if (op_valid_i) begin
      flags_d = (flags_q & ~mask_w) | (cand & mask_w); // RULE16
    end else if (bus_flag_wr) begin
      flags_d = wb_dat_i[NFLAGS-1:0]; // RULE1
    end
  end

  // Condition register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= FLAGS_RST;
    end else begin
      flags_q <= flags_d; // RULE18
    end
  end

  // Result write-back, same edge as the flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_q <= '0;
      result_valid_q <= 1'h0;
    end else begin
      result_valid_q <= op_valid_i; // RULE18
      if (op_valid_i) begin
        // Store returns the register, datapath otherwise
        if (op_i == STORE_FLAGS_INSTR) begin
          result_q <= {{(DATA_W-NFLAGS){1'h0}}, flags_q}; // RULE1
        end else begin
          result_q <= alu.result;
        end
      end
    end
  end

  assign result_o = result_q;
  assign result_valid_o = result_valid_q;
  // Upper two bits belong to other logic and read zero
  assign flags_o = {{(CREG_W-NFLAGS){1'h0}}, flags_q};

  // Branch condition over sign, zero, overflow, carry
  function automatic logic cond_true(cond_type cc, logic [NFLAGS-1:0] f);
    logic n;
    logic z;
    logic v;
    logic c;
    n = f[FLAG_N];
    z = f[FLAG_Z];
    v = f[FLAG_V];
    c = f[FLAG_C];
    unique case (cc)
      COND_ALWAYS: return 1'h1;
      COND_NEVER: return 1'h0;
      COND_HI: return !(c || z);
      COND_LS: return c || z;
      COND_CC: return !c;
      COND_CS: return c;
      COND_NE: return !z;
      COND_EQ: return z;
      COND_VC: return !v;
      COND_VS: return v;
      COND_PL: return !n;
      COND_MI: return n;
      COND_GE: return !(n ^ v);
      COND_LT: return n ^ v;
      COND_GT: return !(z || (n ^ v));
      COND_LE: return z || (n ^ v);
    endcase
  endfunction

  // Taken decision from the committed flags
  assign branch_taken_o = cond_true(cond_i, flags_q); // RULE17

  // Word, longword and fetch addresses lose bit 0, no error
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_q <= '0;
      addr_valid_q <= 1'h0;
    end else begin
      addr_valid_q <= addr_req_i;
      if (addr_req_i) begin
        if (addr_size_i != SZ_BYTE || addr_fetch_i) begin
          addr_q <= {addr_i[ADDR_W-1:1], 1'h0}; // RULE12 RULE13
        end else begin
          addr_q <= addr_i;
        end
      end
    end
  end

  assign addr_o = addr_q;
  assign addr_valid_o = addr_valid_q;

  // Acknowledge one cycle after request, drop next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'h0;
    end else begin
      ack_q <= bus_req;
    end
  end

  // Read data captured when the request is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else if (bus_req) begin
      unique case (wb_adr_i)
        FLAGS_OFF: rdata_q <= {{(DATA_W-NFLAGS){1'h0}}, flags_q};
        RESULT_OFF: rdata_q <= result_q;
        // Unmapped reads zero
        default: rdata_q <= '0;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // Helpers for independent flag checks
  logic [DATA_W:0] long_sum_w;
  logic opa_bit_w;
  assign long_sum_w = {1'h0, opa_i} + {1'h0, opb_i};
  assign opa_bit_w = opa_i[bit_idx_i];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Named steps
  sequence wb_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence wb_answer_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence align_req_s;
    addr_req_i && (addr_size_i != SZ_BYTE || addr_fetch_i);
  endsequence
  sequence add_long_s;
    op_valid_i && op_i == OP_ADD && size_i == SZ_LONG;
  endsequence

  user_bit_guard_a: assert property ( // RULE1
    $changed(flags_q[FLAG_U]) |-> $past(flag_load_any))
    else $error("user bit changed without a flag load");

  sign_flag_a: assert property ( // RULE2
    op_valid_i && op_i == OP_ADD
    |=> flags_q[FLAG_N] == result_q[msb_pos($past(size_i))])
    else $error("sign flag differs from result sign");

  zero_flag_a: assert property ( // RULE3
    op_valid_i && mask_w[FLAG_Z] && !(op_i inside {LOAD_FLAGS_INSTR, AND_FLAGS_INSTR,
    OR_FLAGS_INSTR, XOR_FLAGS_INSTR}) |=> flags_q[FLAG_Z] == (result_q == '0))
    else $error("zero flag differs from result");

  overflow_clear_a: assert property ( // RULE4
    op_valid_i && op_i == OP_MOV |=> !flags_q[FLAG_V])
    else $error("overflow not cleared on move");

  add_carry_a: assert property ( // RULE5
    add_long_s |=> flags_q[FLAG_C] == $past(long_sum_w[DATA_W]))
    else $error("addition carry wrong");

  sub_borrow_a: assert property ( // RULE6
    op_valid_i && op_i == OP_SUB && size_i == SZ_LONG
    |=> flags_q[FLAG_C] == $past(opa_i < opb_i))
    else $error("subtraction borrow wrong");

  shift_carry_a: assert property ( // RULE7
    op_valid_i && op_i == OP_SHL && size_i == SZ_BYTE
    |=> flags_q[FLAG_C] == $past(opa_i[MSB_BYTE]))
    else $error("shift carry wrong");

  bit_load_a: assert property ( // RULE8
    op_valid_i && op_i == OP_BLD |=> flags_q[FLAG_C] == $past(opa_bit_w))
    else $error("bit load carry wrong");

  flag_hold_a: assert property ( // RULE16
    op_valid_i && op_i == OP_BST |=> $stable(flags_q))
    else $error("flags moved on bit store");

  align_even_a: assert property ( // RULE12
    align_req_s |=> addr_valid_o && !addr_o[0]
    && addr_o[ADDR_W-1:1] == $past(addr_i[ADDR_W-1:1]))
    else $error("aligned address wrong");

  branch_eq_a: assert property ( // RULE17
    cond_i == COND_EQ |-> branch_taken_o == flags_q[FLAG_Z])
    else $error("equal branch ignores zero flag");

  wb_ack_a: assert property (wb_req_s |=> wb_answer_s)
    else $error("bus acknowledge timing wrong");

  writeback_sync_a: assert property ( // RULE18
    op_valid_i |=> result_valid_o ##1 !result_valid_o || $past(op_valid_i))
    else $error("write-back pulse wrong");
endmodule

// [bench/testbench.sv]
// Self-checking bench for the condition flag unit
`timescale 1ns/1ps
module testbench;
  import flag_unit_pkg::*;
  // Design connections
  logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, op_valid_i, result_valid_o;
  logic branch_taken_o, addr_req_i, addr_fetch_i, addr_valid_o;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, opa_i, opb_i, result_o;
  logic [2:0] bit_idx_i;
  logic [7:0] imm_i, flags_o;
  logic [23:0] addr_i, addr_o;
  op_type op_i;
  size_type size_i, addr_size_i;
  cond_type cond_i;
  // Reference state and counters
  logic [5:0] mf;
  logic [31:0] mr, rd;
  int num_errors = 0;
  int tests_run = 0;
  op_type fl[5] = '{LOAD_FLAGS_INSTR, AND_FLAGS_INSTR, OR_FLAGS_INSTR, XOR_FLAGS_INSTR,
    STORE_FLAGS_INSTR};
  op_type ar[9] = '{OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_SHL, OP_MOV, OP_SHR, OP_ROTL,
    OP_ROTR};
  op_type bo[5] = '{OP_BLD, OP_BAND, OP_BOR, OP_BXOR, OP_BST};

  flag_unit uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .op_valid_i(op_valid_i), .op_i(op_i),
    .size_i(size_i), .opa_i(opa_i), .opb_i(opb_i), .bit_idx_i(bit_idx_i), .imm_i(imm_i),
    .result_o(result_o), .result_valid_o(result_valid_o), .flags_o(flags_o), .cond_i(cond_i),
    .branch_taken_o(branch_taken_o), .addr_req_i(addr_req_i), .addr_i(addr_i),
    .addr_size_i(addr_size_i), .addr_fetch_i(addr_fetch_i), .addr_o(addr_o),
    .addr_valid_o(addr_valid_o));

  // 125 MHz clock
  initial begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end

  // Verdict and end of run
  task automatic results();
    if (num_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Single comparison point
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Classic Wishbone single cycle, bounded wait for ack
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] sel);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sel;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    if (wb_ack_o !== 1'h1) begin
      num_errors++;
      results();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask

  // Zero-extended low n bits
  function automatic logic [32:0] lo(input logic [31:0] x, input int n);
    return {1'h0, x & ((32'h1 << n) - 32'h1)};
  endfunction

  // Issue one instruction, model it, compare one cycle later
  task automatic op(input op_type o, input size_type s, input logic [31:0] a,
                    input logic [31:0] b, input logic [2:0] ix, input logic [7:0] im);
    int msb;
    logic [32:0] w, hw;
    logic [31:0] r;
    logic [5:0] f;
    logic ci, nz, cr, ad;
    msb = (s == SZ_BYTE || (o >= OP_BLD && o <= DECIMAL_ADJUST_SUB)) ? 7 :
          (s == SZ_WORD) ? 15 : 31;
    f = mf;
    nz = 1'h0;
    cr = 1'h1;
    ci = (o == OP_ADDC || o == OP_SUBC) ? mf[0] : 1'h0;
    ad = (o == OP_ADD || o == OP_ADDC);
    r = lo(a, msb + 1);
    case (o)
      OP_ADD, OP_ADDC, OP_SUB, OP_SUBC: begin
        w = ad ? lo(a, msb + 1) + lo(b, msb + 1) + ci : lo(a, msb + 1) - lo(b, msb + 1) - ci;
        hw = ad ? lo(a, msb - 3) + lo(b, msb - 3) + ci : lo(a, msb - 3) - lo(b, msb - 3) - ci;
        r = lo(w[31:0], msb + 1);
        f[0] = w[msb + 1];
        f[5] = hw[msb - 3];
        f[1] = ((a[msb] == b[msb]) == ad) && (r[msb] != a[msb]);
        nz = 1'h1;
      end
      OP_MOV, OP_SHL, OP_SHR, OP_ROTL, OP_ROTR: begin
        if (o == OP_SHL || o == OP_ROTL) begin
          r = lo((a << 1) | 32'(o == OP_ROTL && a[msb]), msb + 1);
          f[0] = a[msb];
        end else if (o != OP_MOV) begin
          r = (r >> 1) | (32'(o == OP_ROTR && a[0]) << msb);
          f[0] = a[0];
        end
        f[1] = 1'h0;
        nz = 1'h1;
      end
      OP_BLD: f[0] = a[ix];
      OP_BAND: f[0] = mf[0] & a[ix];
      OP_BOR: f[0] = mf[0] | a[ix];
      OP_BXOR: f[0] = mf[0] ^ a[ix];
      OP_BST: r[ix] = mf[0];
      DECIMAL_ADJUST_ADD: begin
        f[0] = mf[0] | (r > 32'h99);
        if (mf[5] || r[3:0] > 4'h9) r = r + 32'h6;
        if (f[0]) r = r + 32'h60;
        r = r & 32'hFF;
        nz = 1'h1;
      end
      DECIMAL_ADJUST_SUB: begin
        if (mf[5]) r = r - 32'h6;
        if (mf[0]) r = r - 32'h60;
        r = r & 32'hFF;
        nz = 1'h1;
      end
      LOAD_FLAGS_INSTR: f = im[5:0];
      AND_FLAGS_INSTR: f = mf & im[5:0];
      OR_FLAGS_INSTR: f = mf | im[5:0];
      XOR_FLAGS_INSTR: f = mf ^ im[5:0];
      STORE_FLAGS_INSTR: r = {26'h0, mf};
      default: cr = 1'h0;
    endcase
    if (o inside {OP_BLD, OP_BAND, OP_BOR, OP_BXOR} || o >= LOAD_FLAGS_INSTR) cr = o == STORE_FLAGS_INSTR;
    if (nz) begin
      f[3] = r[msb];
      f[2] = (r == 32'h0);
    end
    op_valid_i <= 1'h1;
    op_i <= o;
    size_i <= s;
    opa_i <= a;
    opb_i <= b;
    bit_idx_i <= ix;
    imm_i <= im;
    @(posedge clk_i);
    #1;
    check("result_valid", 32'(result_valid_o), 32'h1);
    check("flags", 32'(flags_o), {26'h0, f});
    if (cr) begin
      check("result", result_o, r);
      mr = r;
    end
    mf = f;
  endtask

  // Address alignment request
  task automatic align(input logic [23:0] a, input size_type s, input logic f);
    addr_req_i <= 1'h1;
    addr_i <= a;
    addr_size_i <= s;
    addr_fetch_i <= f;
    @(posedge clk_i);
    #1;
    check("addr_valid", 32'(addr_valid_o), 32'h1);
    check("addr", 32'(addr_o), 32'((s != SZ_BYTE || f) ? a & 24'hFFFFFE : a));
  endtask

  // Main sequence
  initial begin
    logic [15:0] t;
    {wb_we_i, wb_cyc_i, wb_stb_i, op_valid_i, addr_req_i, addr_fetch_i} = 6'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i, opa_i, opb_i, bit_idx_i, imm_i, addr_i} = '0;
    op_i = OP_NOP;
    size_i = SZ_BYTE;
    addr_size_i = SZ_BYTE;
    cond_i = COND_ALWAYS;
    void'($urandom(97132));
    rst_i = 1'h1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    mf = FLAGS_RST;
    // Register reset value and bus access
    wb(1'h0, FLAGS_OFF, 32'h0, 4'hF);
    check("flags_reg_rst", rd, {26'h0, mf});
    wb(1'h1, FLAGS_OFF, 32'hFF, 4'hF);
    wb(1'h1, FLAGS_OFF, 32'h15, 4'hE);
    wb(1'h0, FLAGS_OFF, 32'h0, 4'hF);
    check("flags_reg", rd, 32'h3F);
    wb(1'h1, FLAGS_OFF, 32'h15, 4'h1);
    wb(1'h1, 4'hC, 32'h2A, 4'hF);
    wb(1'h0, 4'hC, 32'h0, 4'hF);
    check("unmapped", rd, 32'h0);
    mf = 6'h15;
    check("flags_out", 32'(flags_o), 32'h15);
    // Flag instructions, then no-op keeps flags
    repeat (4) foreach (fl[i]) op(fl[i], SZ_BYTE, $urandom, 32'h0, 3'h0, 8'($urandom));
    op(OP_NOP, SZ_LONG, $urandom, $urandom, 3'h0, 8'h0);
    // Boundary and random arithmetic, back to back
    op(OP_ADD, SZ_BYTE, 32'h7F, 32'h1, 3'h0, 8'h0);
    op(OP_ADD, SZ_WORD, 32'hFFFF, 32'h1, 3'h0, 8'h0);
    op(OP_SUB, SZ_LONG, 32'h0, 32'h1, 3'h0, 8'h0);
    op(OP_ADD, SZ_LONG, 32'h0FFF_FFFF, 32'h1, 3'h0, 8'h0);
    repeat (60) op(ar[$urandom_range(8)], size_type'($urandom_range(2)), $urandom, $urandom,
      3'h0, 8'h0);
    op_valid_i <= 1'h0;
    wb(1'h1, RESULT_OFF, 32'h0, 4'hF);
    wb(1'h0, RESULT_OFF, 32'h0, 4'hF);
    check("result_reg", rd, mr);
    // Bit manipulation over every index
    for (int k = 0; k < 8; k++) foreach (bo[i]) op(bo[i], SZ_LONG, $urandom, 32'h0, 3'(k), 8'h0);
    // Decimal adjust after add and subtract
    repeat (6) begin
      op(OP_ADD, SZ_BYTE, 32'($urandom_range(153)), 32'($urandom_range(153)), 3'h0, 8'h0);
      op(DECIMAL_ADJUST_ADD, SZ_BYTE, mr, 32'h0, 3'h0, 8'h0);
      op(OP_SUB, SZ_BYTE, 32'($urandom_range(153)), 32'($urandom_range(153)), 3'h0, 8'h0);
      op(DECIMAL_ADJUST_SUB, SZ_BYTE, mr, 32'h0, 3'h0, 8'h0);
    end
    // Branch conditions from loaded flags
    repeat (8) begin
      op(LOAD_FLAGS_INSTR, SZ_BYTE, 32'h0, 32'h0, 3'h0, 8'($urandom));
      op_valid_i <= 1'h0;
      t = {mf[2] | (mf[3] ^ mf[1]), !mf[2] & !(mf[3] ^ mf[1]), mf[3] ^ mf[1], !(mf[3] ^ mf[1]),
           mf[3], !mf[3], mf[1], !mf[1], mf[2], !mf[2], mf[0], !mf[0], mf[0] | mf[2],
           !(mf[0] | mf[2]), 1'h0, 1'h1};
      for (int k = 0; k < 16; k++) begin
        @(posedge clk_i);
        cond_i <= cond_type'(k);
        #1;
        check("branch", 32'(branch_taken_o), 32'(t[k]));
      end
    end
    // Address alignment for data and fetch
    repeat (24) align(24'($urandom), size_type'($urandom_range(2)), 1'($urandom));
    addr_req_i <= 1'h0;
    results();
  end
endmodule
